//--- verilog/gafs_top.sv
// pin alternate function selector with its register port
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
//
// Overview of operation
// - pin7 input: 0001 low power three, 0010 mask, 0011 level hibernate
// - pin7 output codes 0000..0110 and 1100 pick gpio or listed sources
// - pin6 input: 0001 low power two, 0010 flash, 0011 edge hibernate
// - pin6 input code 0100 is the level hibernate request
// - pin5 input: low power one, adc word clock, edge, power off, level
// - power state machine reset reloads every selector with its default
module gafs_top #(
    parameter logic [15:0] SEL_LOW_RST = gafs_pkg::SEL_LOW_DEF,
    parameter logic [15:0] SEL_MID_RST = gafs_pkg::SEL_MID_DEF
) (
    input  wire logic                          clock_i,
    input  wire logic                          nrst_i,
    input  wire logic                          sm_reset_i,
    input  wire logic [gafs_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [gafs_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [gafs_pkg::DATA_W-1:0]   rdata_o,
    input  wire gafs_pkg::gafs_src_t           src_i,
    output gafs_pkg::gafs_req_t                req_o,
    input  wire logic [gafs_pkg::PINS-1:0]     pin_i,
    output logic      [gafs_pkg::PINS-1:0]     pin_o,
    output logic      [gafs_pkg::PINS-1:0]     pin_oe_o
);
    localparam int PINS = gafs_pkg::PINS;
    localparam int FW   = gafs_pkg::FW;
    localparam int DW   = gafs_pkg::DATA_W;

    logic rst_s1_r;
    logic rst_n;

    logic [DW-1:0]   sel_low_r;
    logic [DW-1:0]   sel_low_nxt;
    logic [DW-1:0]   sel_mid_r;
    logic [DW-1:0]   sel_mid_nxt;
    logic [PINS-1:0] dir_r;
    logic [PINS-1:0] dir_nxt;
    logic [PINS-1:0] gout_r;
    logic [PINS-1:0] gout_nxt;
    logic [DW-1:0]   rdata_r;
    logic [DW-1:0]   rdata_nxt;

    gafs_pkg::gafs_req_t req_r;
    gafs_pkg::gafs_req_t req_nxt;
    logic [PINS-1:0]     prev_r;
    logic [PINS-1:0]     prev_nxt;

    logic [PINS-1:0] level;
    logic [PINS-1:0] rise;
    logic [PINS-1:0] drive;
    logic [FW-1:0]   sel0;
    logic [FW-1:0]   sel4;
    logic [FW-1:0]   sel5;
    logic [FW-1:0]   sel6;
    logic [FW-1:0]   sel7;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // register file
    always_comb begin
        sel_low_nxt = sel_low_r;
        sel_mid_nxt = sel_mid_r;
        dir_nxt     = dir_r;
        gout_nxt    = gout_r;
        rdata_nxt   = gafs_pkg::RD_IDLE;
        if (sm_reset_i) begin
            sel_low_nxt = SEL_LOW_RST;
            sel_mid_nxt = SEL_MID_RST;
        end else if (wr_i) begin
            case (addr_i)
                gafs_pkg::ADDR_SEL_LOW: sel_low_nxt = wdata_i;
                gafs_pkg::ADDR_SEL_MID: sel_mid_nxt = wdata_i;
                default: ;
            endcase
        end
        if (wr_i) begin
            case (addr_i)
                gafs_pkg::ADDR_PIN_DIR:  dir_nxt  = wdata_i[PINS-1:0];
                gafs_pkg::ADDR_GPIO_OUT: gout_nxt = wdata_i[PINS-1:0];
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                gafs_pkg::ADDR_SEL_LOW:   rdata_nxt = sel_low_r;
                gafs_pkg::ADDR_SEL_MID:   rdata_nxt = sel_mid_r;
                gafs_pkg::ADDR_PIN_DIR:   rdata_nxt = {gafs_pkg::RD_PAD, dir_r};
                gafs_pkg::ADDR_GPIO_OUT:  rdata_nxt = {gafs_pkg::RD_PAD, gout_r};
                gafs_pkg::ADDR_PIN_LEVEL: rdata_nxt = {gafs_pkg::RD_PAD, level};
                default:                  rdata_nxt = gafs_pkg::RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_low_r <= SEL_LOW_RST;
            sel_mid_r <= SEL_MID_RST;
            dir_r     <= gafs_pkg::DIR_DEF;
            gout_r    <= gafs_pkg::GOUT_DEF;
            rdata_r   <= gafs_pkg::RD_IDLE;
        end else begin
            sel_low_r <= sel_low_nxt;
            sel_mid_r <= sel_mid_nxt;
            dir_r     <= dir_nxt;
            gout_r    <= gout_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    assign sel0 = sel_low_r[gafs_pkg::F_GP0 +: FW];
    assign sel4 = sel_mid_r[gafs_pkg::F_GP4 +: FW];
    assign sel5 = sel_mid_r[gafs_pkg::F_GP5 +: FW];
    assign sel6 = sel_mid_r[gafs_pkg::F_GP6 +: FW];
    assign sel7 = sel_mid_r[gafs_pkg::F_GP7 +: FW];

    // output tables; unlisted codes and pins 1..3 keep the gpio value
    always_comb begin
        drive = gout_r;
        case (sel0)
            gafs_pkg::SEL_1: drive[gafs_pkg::P_GP0] = src_i.power_on_state;
            gafs_pkg::SEL_2: drive[gafs_pkg::P_GP0] = src_i.vrtc_ok;
            gafs_pkg::SEL_3: drive[gafs_pkg::P_GP0] = src_i.por_b;
            gafs_pkg::SEL_4: drive[gafs_pkg::P_GP0] = src_i.sys_rst_n;
            default: ;
        endcase
        case (sel4)
            gafs_pkg::SEL_1:  drive[gafs_pkg::P_GP4] = src_i.mem_rst_n;
            gafs_pkg::SEL_2:  drive[gafs_pkg::P_GP4] = src_i.aux_detect_alert_out;
            gafs_pkg::SEL_3:  drive[gafs_pkg::P_GP4] = src_i.flash_out;
            gafs_pkg::SEL_4:  drive[gafs_pkg::P_GP4] = src_i.vcc_fault_n;
            gafs_pkg::SEL_5:  drive[gafs_pkg::P_GP4] = src_i.microphone_short_out;
            gafs_pkg::SEL_10: drive[gafs_pkg::P_GP4] = src_i.microphone_detect_out;
            default: ;
        endcase
        case (sel5)
            gafs_pkg::SEL_1:  drive[gafs_pkg::P_GP5] = src_i.p_clk;
            gafs_pkg::SEL_2:  drive[gafs_pkg::P_GP5] = src_i.adc_word_clock_out;
            gafs_pkg::SEL_3:  drive[gafs_pkg::P_GP5] = src_i.clk_32k;
            gafs_pkg::SEL_4:  drive[gafs_pkg::P_GP5] = src_i.battery_fault_n;
            gafs_pkg::SEL_5:  drive[gafs_pkg::P_GP5] = src_i.microphone_short_out;
            gafs_pkg::SEL_6:  drive[gafs_pkg::P_GP5] = src_i.aux_detect_alert_out;
            gafs_pkg::SEL_7:  drive[gafs_pkg::P_GP5] = src_i.codec_opclk;
            gafs_pkg::SEL_10: drive[gafs_pkg::P_GP5] = src_i.microphone_detect_out;
            default: ;
        endcase
        case (sel6)
            gafs_pkg::SEL_1: drive[gafs_pkg::P_GP6] = src_i.mem_rst_n;
            gafs_pkg::SEL_2: drive[gafs_pkg::P_GP6] = src_i.aux_detect_alert_out;
            gafs_pkg::SEL_3: drive[gafs_pkg::P_GP6] = src_i.rtc_out;
            default: ;
        endcase
        case (sel7)
            gafs_pkg::SEL_1: drive[gafs_pkg::P_GP7] = src_i.p_clk;
            gafs_pkg::SEL_2: drive[gafs_pkg::P_GP7] = src_i.vcc_fault_n;
            gafs_pkg::SEL_3: drive[gafs_pkg::P_GP7] = src_i.battery_fault_n;
            gafs_pkg::SEL_4: drive[gafs_pkg::P_GP7] = src_i.microphone_detect_out;
            gafs_pkg::SEL_5: drive[gafs_pkg::P_GP7] = src_i.microphone_short_out;
            gafs_pkg::SEL_6: drive[gafs_pkg::P_GP7] = src_i.aux_detect_alert_out;
            gafs_pkg::SEL_12:
                drive[gafs_pkg::P_GP7] = src_i.freq_locked_loop_clock_out;
            default: ;
        endcase
    end

    // pins driven as outputs reach the drivers and still read back their level; only inputs reach the tables
    for (genvar g = 0; g < PINS; g++) begin : g_pin
        gafs_pin_cell u_cell (
            .clock_i   (clock_i),
            .rst_n_i   (rst_n),
            .dir_out_i (dir_r[g]),
            .drive_i   (drive[g]),
            .pin_i     (pin_i[g]),
            .pin_o     (pin_o[g]),
            .pin_oe_o  (pin_oe_o[g]),
            .level_o   (level[g])
        );
    end

    // an output pin reads back its own level; mask it out of the rise detect
    assign rise = level & ~prev_r & ~dir_r;

    // input tables; several pins on one request are or-ed
    always_comb begin
        req_nxt  = '0;
        prev_nxt = level;
        if (!dir_r[gafs_pkg::P_GP0]) begin
            case (sel0)
                gafs_pkg::SEL_1: req_nxt.power_on_req = level[gafs_pkg::P_GP0];
                gafs_pkg::SEL_2: req_nxt.ldo_enable_req = !level[gafs_pkg::P_GP0];
                gafs_pkg::SEL_3:
                    req_nxt.low_power_req_one = level[gafs_pkg::P_GP0];
                gafs_pkg::SEL_4:
                    req_nxt.power_down_request = level[gafs_pkg::P_GP0];
                gafs_pkg::SEL_5: req_nxt.chip_reset_req = level[gafs_pkg::P_GP0];
                default: ;
            endcase
        end
        if (!dir_r[gafs_pkg::P_GP4]) begin
            case (sel4)
                gafs_pkg::SEL_1:
                    req_nxt.manual_reset_req = !level[gafs_pkg::P_GP4];
                gafs_pkg::SEL_2: req_nxt.flash_trigger = level[gafs_pkg::P_GP4];
                gafs_pkg::SEL_3: req_nxt.hib_level_req = level[gafs_pkg::P_GP4];
                gafs_pkg::SEL_4: req_nxt.mask_req = level[gafs_pkg::P_GP4];
                gafs_pkg::SEL_5: req_nxt.chip_reset_req =
                    req_nxt.chip_reset_req | level[gafs_pkg::P_GP4];
                default: ;
            endcase
        end
        if (!dir_r[gafs_pkg::P_GP5]) begin
            case (sel5)
                gafs_pkg::SEL_1: req_nxt.low_power_req_one =
                    req_nxt.low_power_req_one | level[gafs_pkg::P_GP5];
                gafs_pkg::SEL_2: req_nxt.adc_word_clock = level[gafs_pkg::P_GP5];
                gafs_pkg::SEL_3: req_nxt.hib_edge_req = rise[gafs_pkg::P_GP5];
                gafs_pkg::SEL_4: req_nxt.power_down_request =
                    req_nxt.power_down_request | level[gafs_pkg::P_GP5];
                gafs_pkg::SEL_5: req_nxt.hib_level_req =
                    req_nxt.hib_level_req | level[gafs_pkg::P_GP5];
                default: ;
            endcase
        end
        if (!dir_r[gafs_pkg::P_GP6]) begin
            case (sel6)
                gafs_pkg::SEL_1:
                    req_nxt.low_power_req_two = level[gafs_pkg::P_GP6];
                gafs_pkg::SEL_2: req_nxt.flash_trigger =
                    req_nxt.flash_trigger | level[gafs_pkg::P_GP6];
                gafs_pkg::SEL_3: req_nxt.hib_edge_req =
                    req_nxt.hib_edge_req | rise[gafs_pkg::P_GP6];
                gafs_pkg::SEL_4: req_nxt.hib_level_req =
                    req_nxt.hib_level_req | level[gafs_pkg::P_GP6];
                default: ;
            endcase
        end
        if (!dir_r[gafs_pkg::P_GP7]) begin
            case (sel7)
                gafs_pkg::SEL_1:
                    req_nxt.low_power_req_three = level[gafs_pkg::P_GP7];
                gafs_pkg::SEL_2: req_nxt.mask_req =
                    req_nxt.mask_req | level[gafs_pkg::P_GP7];
                gafs_pkg::SEL_3: req_nxt.hib_level_req =
                    req_nxt.hib_level_req | level[gafs_pkg::P_GP7];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            req_r  <= '0;
            prev_r <= '0;
        end else begin
            req_r  <= req_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign req_o = req_r;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    sm_reset_default_a: assert property (
        sm_reset_i |=> sel_low_r == SEL_LOW_RST && sel_mid_r == SEL_MID_RST)
        else $error("selectors not reloaded by state machine reset");
    pin7_lowpwr_a: assert property (
        !dir_r[7] && sel7 == gafs_pkg::SEL_1 && level[7]
        |=> req_o.low_power_req_three)
        else $error("pin7 low power three not raised");
    pin7_fll_out_a: assert property (
        dir_r[7] && sel7 == gafs_pkg::SEL_12
        |=> pin_o[7] == $past(src_i.freq_locked_loop_clock_out))
        else $error("pin7 loop clock not driven");
    pin6_edge_hib_a: assert property (
        !dir_r[6] && sel6 == gafs_pkg::SEL_3 && level[6] && !prev_r[6]
        |=> req_o.hib_edge_req ##1 1'b1)
        else $error("pin6 edge hibernate missed");
    pin6_level_hib_a: assert property (
        (!dir_r[6] && sel6 == gafs_pkg::SEL_4 && level[6])[*2]
        |=> req_o.hib_level_req)
        else $error("pin6 level hibernate missed");
    pin5_power_off_a: assert property (
        !dir_r[5] && sel5 == gafs_pkg::SEL_4 && level[5]
        |=> req_o.power_down_request)
        else $error("pin5 power off missed");
    unlisted_gpio_a: assert property (
        dir_r[gafs_pkg::P_GP7] && sel7 > gafs_pkg::SEL_6
        && sel7 != gafs_pkg::SEL_12
        |=> pin_o[gafs_pkg::P_GP7] == $past(gout_r[gafs_pkg::P_GP7]))
        else $error("unlisted code does not fall back to gpio");
    read_back_a: assert property (
        rd_i && addr_i == gafs_pkg::ADDR_SEL_MID |=> rdata_o == $past(sel_mid_r))
        else $error("selector read back wrong");

    fll_out_c: cover property (dir_r[7] && sel7 == gafs_pkg::SEL_12);
    edge_hib_c: cover property (req_o.hib_edge_req);
    sm_reset_c: cover property (sm_reset_i ##2 rd_i);
endmodule

//--- verilog/gafs_pkg.sv
// constants and carrier types of the pin alternate function selector
package gafs_pkg;

    localparam int PINS   = 8;
    localparam int FW     = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register addresses
    localparam logic [ADDR_W-1:0] ADDR_SEL_LOW   = 8'h8c;
    localparam logic [ADDR_W-1:0] ADDR_SEL_MID   = 8'h8d;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DIR   = 8'h9c;
    localparam logic [ADDR_W-1:0] ADDR_GPIO_OUT  = 8'h9d;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = 8'h9e;

    // reset values; selector defaults are mask options
    localparam logic [DATA_W-1:0] SEL_LOW_DEF = 16'h0000;
    localparam logic [DATA_W-1:0] SEL_MID_DEF = 16'h0000;
    localparam logic [PINS-1:0]   DIR_DEF     = 8'h00;
    localparam logic [PINS-1:0]   GOUT_DEF    = 8'h00;
    localparam logic [DATA_W-1:0] RD_IDLE     = 16'h0000;
    localparam logic [DATA_W-PINS-1:0] RD_PAD = 8'h00;

    // pin indices and selector field positions
    localparam int P_GP0 = 0;
    localparam int P_GP4 = 4;
    localparam int P_GP5 = 5;
    localparam int P_GP6 = 6;
    localparam int P_GP7 = 7;
    localparam int F_GP0 = 0;
    localparam int F_GP4 = 0;
    localparam int F_GP5 = 4;
    localparam int F_GP6 = 8;
    localparam int F_GP7 = 12;

    // selector codes
    localparam logic [FW-1:0] SEL_GPIO = 4'h0;
    localparam logic [FW-1:0] SEL_1    = 4'h1;
    localparam logic [FW-1:0] SEL_2    = 4'h2;
    localparam logic [FW-1:0] SEL_3    = 4'h3;
    localparam logic [FW-1:0] SEL_4    = 4'h4;
    localparam logic [FW-1:0] SEL_5    = 4'h5;
    localparam logic [FW-1:0] SEL_6    = 4'h6;
    localparam logic [FW-1:0] SEL_7    = 4'h7;
    localparam logic [FW-1:0] SEL_10   = 4'ha;
    localparam logic [FW-1:0] SEL_12   = 4'hc;

    // requests towards the power logic, all active high
    typedef struct packed {
        logic power_on_req;
        logic ldo_enable_req;
        logic low_power_req_one;
        logic low_power_req_two;
        logic low_power_req_three;
        logic power_down_request;
        logic chip_reset_req;
        logic manual_reset_req;
        logic flash_trigger;
        logic mask_req;
        logic hib_edge_req;
        logic hib_level_req;
        logic adc_word_clock;
    } gafs_req_t;

    // internal signals that may be routed out to a pin
    typedef struct packed {
        logic power_on_state;
        logic vrtc_ok;
        logic por_b;
        logic sys_rst_n;
        logic mem_rst_n;
        logic aux_detect_alert_out;
        logic flash_out;
        logic vcc_fault_n;
        logic microphone_short_out;
        logic microphone_detect_out;
        logic p_clk;
        logic adc_word_clock_out;
        logic clk_32k;
        logic battery_fault_n;
        logic codec_opclk;
        logic rtc_out;
        logic freq_locked_loop_clock_out;
    } gafs_src_t;

endpackage

//--- verilog/gafs_pin_cell.sv
// one multiplexed pin: registered drive, enable and input level
`timescale 1ns/1ps
module gafs_pin_cell (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic dir_out_i,
    input  wire logic drive_i,
    input  wire logic pin_i,
    output logic      pin_o,
    output logic      pin_oe_o,
    output logic      level_o
);
    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic oe_nxt;
    logic level_r;
    logic level_nxt;

    always_comb begin
        pin_nxt   = drive_i;
        oe_nxt    = dir_out_i;
        level_nxt = pin_i;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_r   <= 1'b0;
            oe_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            pin_r   <= pin_nxt;
            oe_r    <= oe_nxt;
            level_r <= level_nxt;
        end
    end

    assign pin_o    = pin_r;
    assign pin_oe_o = oe_r;
    assign level_o  = level_r;

    pin_oe_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> pin_oe_o == $past(dir_out_i))
        else $error("pin enable does not follow direction");
endmodule

//--- dv/gafs_far_side.sv
// far-side system logic wired to the multiplexed pins
`timescale 1ns/1ps
module gafs_far_side (
    input  wire logic [gafs_pkg::PINS-1:0] drive_i,
    input  wire logic [gafs_pkg::PINS-1:0] pin_o_i,
    input  wire logic [gafs_pkg::PINS-1:0] pin_oe_i,
    output logic      [gafs_pkg::PINS-1:0] pin_level_o
);
    // a pin the device drives shows the device's value, never ours
    always_comb begin
        for (int k = 0; k < gafs_pkg::PINS; k++) begin
            pin_level_o[k] = pin_oe_i[k] ? pin_o_i[k] : drive_i[k];
        end
    end
endmodule

//--- dv/gafs_bench.sv
// self-checking bench for the pin alternate function selector
`timescale 1ns/1ps
module gpio_alt_function_select_bench;
    // nonzero mask defaults so a state machine reset is visible
    localparam logic [15:0] LOW_RST = 16'h0305;
    localparam logic [15:0] MID_RST = 16'h2000;
    typedef struct packed {
        logic [15:0] mid;
        logic [7:0]  dir;
        logic [7:0]  gout;
        logic [7:0]  ext;
        logic [16:0] src;
        logic [12:0] req;
        logic [7:0]  po;
    } gafs_row_t;
    localparam gafs_row_t ROWS [35] = '{
        '{16'h1000, 8'h00, 8'h00, 8'h80, 17'h0_0000, 13'h0100, 8'h00},
        '{16'h2000, 8'h00, 8'h00, 8'h80, 17'h0_0000, 13'h0008, 8'h00},
        '{16'h3000, 8'h00, 8'h00, 8'h80, 17'h0_0000, 13'h0002, 8'h00},
        '{16'h1000, 8'h00, 8'h00, 8'h00, 17'h0_0000, 13'h0000, 8'h00},
        '{16'h0100, 8'h00, 8'h00, 8'h40, 17'h0_0000, 13'h0200, 8'h00},
        '{16'h0200, 8'h00, 8'h00, 8'h40, 17'h0_0000, 13'h0010, 8'h00},
        '{16'h0400, 8'h00, 8'h00, 8'h40, 17'h0_0000, 13'h0002, 8'h00},
        '{16'h0010, 8'h00, 8'h00, 8'h20, 17'h0_0000, 13'h0400, 8'h00},
        '{16'h0020, 8'h00, 8'h00, 8'h20, 17'h0_0000, 13'h0001, 8'h00},
        '{16'h0040, 8'h00, 8'h00, 8'h20, 17'h0_0000, 13'h0080, 8'h00},
        '{16'h0050, 8'h00, 8'h00, 8'h20, 17'h0_0000, 13'h0002, 8'h00},
        '{16'h0003, 8'h00, 8'h00, 8'h10, 17'h0_0000, 13'h0002, 8'h00},
        '{16'h0060, 8'h00, 8'h00, 8'h20, 17'h0_0000, 13'h0000, 8'h00},
        '{16'h7000, 8'h00, 8'h00, 8'h80, 17'h0_0000, 13'h0000, 8'h00},
        '{16'h0000, 8'h80, 8'h80, 8'h00, 17'h0_0000, 13'h0000, 8'h80},
        '{16'h1000, 8'h80, 8'h00, 8'h00, 17'h0_0040, 13'h0000, 8'h80},
        '{16'h2000, 8'h80, 8'h00, 8'h00, 17'h0_0200, 13'h0000, 8'h80},
        '{16'h3000, 8'h80, 8'h00, 8'h00, 17'h0_0008, 13'h0000, 8'h80},
        '{16'h4000, 8'h80, 8'h00, 8'h00, 17'h0_0080, 13'h0000, 8'h80},
        '{16'h5000, 8'h80, 8'h00, 8'h00, 17'h0_0100, 13'h0000, 8'h80},
        '{16'h6000, 8'h80, 8'h00, 8'h00, 17'h0_0800, 13'h0000, 8'h80},
        '{16'hc000, 8'h80, 8'h00, 8'h00, 17'h0_0001, 13'h0000, 8'h80},
        '{16'h8000, 8'h80, 8'h00, 8'h00, 17'h1_ffff, 13'h0000, 8'h00},
        '{16'h1000, 8'h80, 8'h00, 8'h80, 17'h0_0040, 13'h0000, 8'h80},
        '{16'h0001, 8'h00, 8'h00, 8'h00, 17'h0_0000, 13'h0020, 8'h00},
        '{16'h0002, 8'h00, 8'h00, 8'h10, 17'h0_0000, 13'h0010, 8'h00},
        '{16'h0004, 8'h00, 8'h00, 8'h10, 17'h0_0000, 13'h0008, 8'h00},
        '{16'h0005, 8'h00, 8'h00, 8'h10, 17'h0_0000, 13'h0040, 8'h00},
        '{16'h0001, 8'h10, 8'h00, 8'h00, 17'h0_1000, 13'h0000, 8'h10},
        '{16'h0001, 8'h10, 8'h00, 8'h00, 17'h0_0000, 13'h0000, 8'h00},
        '{16'h000a, 8'h10, 8'h00, 8'h00, 17'h0_0080, 13'h0000, 8'h10},
        '{16'h0070, 8'h20, 8'h00, 8'h00, 17'h0_0004, 13'h0000, 8'h20},
        '{16'h0030, 8'h20, 8'h00, 8'h00, 17'h0_0010, 13'h0000, 8'h20},
        '{16'h0300, 8'h40, 8'h00, 8'h00, 17'h0_0002, 13'h0000, 8'h40},
        '{16'h0600, 8'h40, 8'h00, 8'h00, 17'h1_ffff, 13'h0000, 8'h00}
    };
    logic                      clock_i    = 1'b0;
    logic                      nrst_i     = 1'b0;
    logic                      sm_reset_i = 1'b0;
    logic                      wr_i       = 1'b0;
    logic                      rd_i       = 1'b0;
    logic [7:0]                addr_i     = 8'h00;
    logic [15:0]               wdata_i    = 16'h0000;
    logic [15:0]               rdata_o;
    gafs_pkg::gafs_src_t       src_i      = '0;
    gafs_pkg::gafs_req_t       req_o;
    logic [7:0]                ext_lvl    = 8'h00;
    logic [7:0]                pin_i;
    logic [7:0]                pin_o;
    logic [7:0]                pin_oe_o;
    int                        error_cnt  = 0;
    int                        check_count = 0;

    always #20 clock_i = ~clock_i;

    gafs_top #(.SEL_LOW_RST(LOW_RST), .SEL_MID_RST(MID_RST)) dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .sm_reset_i(sm_reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .src_i(src_i), .req_o(req_o), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o)
    );
    gafs_far_side far (
        .drive_i(ext_lvl), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
        .pin_level_o(pin_i)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("mismatches %0d of %0d checks", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // strobes are dropped one edge later, then one idle edge
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        chk(rdata_o, exp);
        @(posedge clock_i);
    endtask

    task automatic settle;
        repeat (4) @(posedge clock_i);
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        test_done();
    end

    initial begin
        int cnt;
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd_chk(gafs_pkg::ADDR_SEL_LOW, LOW_RST);
        rd_chk(gafs_pkg::ADDR_SEL_MID, MID_RST);
        @(negedge clock_i);
        chk(rdata_o, gafs_pkg::RD_IDLE);
        chk(pin_oe_o, 8'h00);
        @(posedge clock_i);
        rd_chk(8'h80, gafs_pkg::RD_IDLE);
        foreach (ROWS[i]) begin
            reg_wr(gafs_pkg::ADDR_SEL_MID, ROWS[i].mid);
            reg_wr(gafs_pkg::ADDR_PIN_DIR, {8'h00, ROWS[i].dir});
            reg_wr(gafs_pkg::ADDR_GPIO_OUT, {8'h00, ROWS[i].gout});
            ext_lvl <= ROWS[i].ext;
            src_i   <= gafs_pkg::gafs_src_t'(ROWS[i].src);
            settle();
            @(negedge clock_i);
            chk(req_o, ROWS[i].req);
            chk(pin_o & ROWS[i].dir, ROWS[i].po);
            chk(pin_oe_o, ROWS[i].dir);
            @(posedge clock_i);
        end
        // edge hibernate: one pulse per rising edge, none while held
        for (int p = 5; p < 7; p++) begin
            ext_lvl <= 8'h00;
            src_i   <= '0;
            reg_wr(gafs_pkg::ADDR_PIN_DIR, 16'h0000);
            reg_wr(gafs_pkg::ADDR_SEL_MID, (p == 5) ? 16'h0030 : 16'h0300);
            settle();
            ext_lvl <= 8'h01 << p;
            cnt = 0;
            repeat (8) begin
                @(negedge clock_i);
                if (req_o.hib_edge_req === 1'b1) cnt++;
            end
            chk(cnt, 1);
            chk(req_o.hib_level_req, 1'b0);
            @(posedge clock_i);
        end
        // level register is read-only
        ext_lvl <= 8'ha5;
        reg_wr(gafs_pkg::ADDR_SEL_MID, 16'h1000);
        reg_wr(gafs_pkg::ADDR_PIN_LEVEL, 16'h005a);
        settle();
        rd_chk(gafs_pkg::ADDR_PIN_LEVEL, 16'h00a5);
        @(negedge clock_i);
        // pin0 still carries the chip reset code of the mask default
        chk(req_o, 13'h0140);
        @(posedge clock_i);
        // state machine reset wins over a write in the same cycle
        reg_wr(gafs_pkg::ADDR_PIN_DIR, 16'h000f);
        reg_wr(gafs_pkg::ADDR_SEL_LOW, 16'h1234);
        addr_i     <= gafs_pkg::ADDR_SEL_MID;
        wdata_i    <= 16'hffff;
        wr_i       <= 1'b1;
        sm_reset_i <= 1'b1;
        @(posedge clock_i);
        wr_i       <= 1'b0;
        sm_reset_i <= 1'b0;
        @(posedge clock_i);
        rd_chk(gafs_pkg::ADDR_SEL_LOW, LOW_RST);
        rd_chk(gafs_pkg::ADDR_SEL_MID, MID_RST);
        rd_chk(gafs_pkg::ADDR_PIN_DIR, 16'h000f);
        settle();
        @(negedge clock_i);
        chk(req_o, 13'h0008);
        @(posedge clock_i);
        // mid-run reset: selectors, direction and requests back to defaults
        reg_wr(gafs_pkg::ADDR_SEL_MID, 16'h4444);
        nrst_i <= 1'b0;
        @(posedge clock_i);
        @(negedge clock_i);
        chk(pin_oe_o, 8'h00);
        chk(req_o, 13'h0000);
        @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd_chk(gafs_pkg::ADDR_SEL_MID, MID_RST);
        rd_chk(gafs_pkg::ADDR_PIN_DIR, 16'h0000);
        settle();
        @(negedge clock_i);
        chk(req_o, 13'h0048);
        @(posedge clock_i);
        test_done();
    end
endmodule
